// [rtl/lpmc_map.vh]
// Constants for the low-power mode controller
`ifndef LPMC_MAP_VH
`define LPMC_MAP_VH

// Power mode codes (request and granted)
`define LPMC_MODE_RUN        3'h0
`define LPMC_MODE_CPUOFF_A   3'h1
`define LPMC_MODE_CPUOFF_B   3'h2
`define LPMC_MODE_STANDBY_A  3'h3
`define LPMC_MODE_STANDBY_B  3'h4
`define LPMC_MODE_FULL_OFF   3'h5
`define LPMC_MODE_RTC_SHUT   3'h6
`define LPMC_MODE_DEEP_SHUT  3'h7

// Peripheral clock classes
`define LPMC_CLS_NONE        2'h0
`define LPMC_CLS_UNCLK       2'h1
`define LPMC_CLS_LF          2'h2
`define LPMC_CLS_HF          2'h3

// Peripheral clock sources
`define LPMC_SRC_SUB         2'h0
`define LPMC_SRC_AUX         2'h1
`define LPMC_SRC_MODULE_OSCILLATOR      2'h2
`define LPMC_SRC_EXT         2'h3

// Peripheral kinds
`define LPMC_KIND_UART       3'h0
`define LPMC_KIND_I2C_TGT    3'h1
`define LPMC_KIND_CONV       3'h2
`define LPMC_KIND_TIMER      3'h3
`define LPMC_KIND_STATIC     3'h4
`define LPMC_KIND_GENERIC    3'h5

// Slow/fast boundary for peripheral clocks, in Hz
`define LPMC_LF_LIMIT_HZ     50000

// Wake-up delays, in ns, and cycle counts at 25 MHz (40 ns)
`define LPMC_CLK_NS          40
`define LPMC_WAKE_FAST_NS    240
`define LPMC_WAKE_NVM_NS     2000
`define LPMC_WAKE_FAST_CYC   ((`LPMC_WAKE_FAST_NS + `LPMC_CLK_NS - 1) / `LPMC_CLK_NS)
`define LPMC_WAKE_NVM_CYC    ((`LPMC_WAKE_NVM_NS + `LPMC_CLK_NS - 1) / `LPMC_CLK_NS)

// Number of classified peripherals
`define LPMC_NPER            8

`endif

// [rtl/lpmc_classify.v]
// One peripheral's clock-need classifier
`timescale 1ns/100ps
`default_nettype none
`include "lpmc_map.vh"

module lpmc_classify (
  input  wire       active,     // Peripheral enabled
  input  wire [2:0] kind,       // Peripheral kind
  input  wire [1:0] src,        // Selected clock source
  input  wire       ext_fast,   // External clock above limit
  input  wire       idle_wait,  // Waiting for edge, START or trigger
  output reg  [1:0] cls         // Resulting class
);

  always @* begin
    cls = `LPMC_CLS_NONE;
    if (active) begin
      case (kind)
        `LPMC_KIND_UART: begin
          if (idle_wait)
            cls = `LPMC_CLS_UNCLK;
          else if (src == `LPMC_SRC_AUX)
            cls = `LPMC_CLS_LF;
          else
            cls = `LPMC_CLS_HF;
        end
        `LPMC_KIND_I2C_TGT: begin
          if (idle_wait || !ext_fast)
            cls = `LPMC_CLS_UNCLK;
          else
            cls = `LPMC_CLS_HF;
        end
        `LPMC_KIND_CONV: begin
          if (idle_wait)
            cls = `LPMC_CLS_UNCLK;
          else if (src == `LPMC_SRC_AUX)
            cls = `LPMC_CLS_LF;
          else
            cls = `LPMC_CLS_HF;
        end
        `LPMC_KIND_TIMER: begin
          if (src == `LPMC_SRC_EXT)
            cls = ext_fast ? `LPMC_CLS_HF : `LPMC_CLS_UNCLK;
          else if (src == `LPMC_SRC_AUX)
            cls = `LPMC_CLS_LF;
          else
            cls = `LPMC_CLS_HF;
        end
        `LPMC_KIND_STATIC:
          cls = `LPMC_CLS_UNCLK;
        `LPMC_KIND_GENERIC: begin
          // Slow external clocks count as unclocked; software keeps them in range
          if (idle_wait)
            cls = `LPMC_CLS_UNCLK;
          else if (src == `LPMC_SRC_EXT)
            cls = ext_fast ? `LPMC_CLS_HF : `LPMC_CLS_UNCLK;
          else if (src == `LPMC_SRC_AUX)
            cls = `LPMC_CLS_LF;
          else
            cls = `LPMC_CLS_HF;
        end
        default:
          cls = `LPMC_CLS_HF;
      endcase
    end
  end

endmodule
`default_nettype wire

// [rtl/lpmc_sync.v]
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/100ps
`default_nettype none

module lpmc_sync #(
  parameter W = 1
) (
  input  wire         ref_clk,  // System clock
  input  wire         arst_n,   // Async reset, active low
  input  wire [W-1:0] d,        // Asynchronous input
  output reg  [W-1:0] q         // Synchronised output
);

  reg [W-1:0] meta_q;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule
`default_nettype wire

// [rtl/lpmc_ctrl.v]
// Low-power mode controller: grant, clock gating, wake-up and DMA visits
//
// Notes on behaviour
// - Run state plus seven software-requested low-power modes
// - Interrupt wakes shallow modes, then same mode resumes
// - Shutdown modes drop core supply, reset on exit
// - Classify peripherals high, low or unclocked
// - Grant deepest mode all peripherals still support
// - DMA trigger briefly runs active, then returns
// - Busy multiplier, CRC, cipher defer entry
// - Vector engine runs only in run, first CPU-off
// - Vector engine not startable in first CPU-off
// - Full-off keeps slow clocks when requested
// - Nonvolatile wake slower only when memory read
// - UART waiting for start edge is unclocked
// - I2C target slow or idle is unclocked
// - Converter class by clock source or trigger wait
// - Timer class by source and external speed
// - Clockless peripherals usable wherever unclocked allowed
`timescale 1ns/100ps
`default_nettype none
`include "lpmc_map.vh"

module lpmc_ctrl (
  input  wire                      ref_clk,           // 25 MHz system clock
  input  wire                      arst_n,            // Async reset, active low
  // CPU side, same clock domain
  input  wire                      lpm_req,           // Pulse: enter requested mode
  input  wire [2:0]                lpm_req_mode,      // Requested low-power mode
  input  wire                      reti,              // Pulse: interrupt service done
  input  wire                      vec_start,         // Pulse: CPU starts vector engine
  input  wire                      vec_done,          // Pulse: vector task finished
  input  wire                      mpy_busy,          // Multiplier operation running
  input  wire                      crc_busy,          // CRC operation running
  input  wire                      aes_busy,          // Cipher operation running
  input  wire                      dma_trigger,       // Pulse: DMA trigger pending
  input  wire                      dma_done,          // Pulse: DMA transfer done
  input  wire                      nvm_disabled,      // Memory switched off by its controller
  input  wire                      wake_reads_nvm,    // Wake path fetches from memory
  input  wire                      sub_clock_disable, // Sub-system clock off request
  input  wire                      supply_supervisor_enable, // Supervisor on in deep shutdown
  input  wire                      slow_clk_req,      // Slow-clock request from RTC/watchdog
  // Peripheral state, one field per peripheral
  input  wire [`LPMC_NPER-1:0]     per_active,        // Peripheral enabled
  input  wire [3*`LPMC_NPER-1:0]   per_kind,          // Peripheral kind
  input  wire [2*`LPMC_NPER-1:0]   per_src,           // Peripheral clock source
  input  wire [`LPMC_NPER-1:0]     per_ext_fast,      // External clock above 50 kHz
  input  wire [`LPMC_NPER-1:0]     per_idle_wait,     // Waiting for edge, START or trigger
  // Asynchronous wake events (pins)
  input  wire                      irq_async,         // Interrupt from a wake source
  input  wire                      rtc_wake_async,    // RTC event in shutdown
  input  wire                      io_wake_async,     // I/O event in shutdown
  // Outputs
  output reg  [2:0]                cur_mode,          // Granted mode
  output reg                       cpu_clk_en,        // CPU running
  output reg                       main_clk_en,       // Main system clock on
  output reg                       sub_clk_en,        // Sub-system clock on
  output reg                       aux_clk_en,        // Auxiliary clock on
  output reg                       lf_xtal_en,        // Low-frequency crystal clock on
  output reg                       vlo_en,            // Very-low-power oscillator on
  output reg                       vec_run,           // Vector engine allowed to run
  output reg                       core_supply_en,    // Core supply on
  output reg                       supervisor_en,     // Supply supervisor on
  output reg                       periph_rst,        // Reset CPU, USS, vector, HF peripherals
  output reg                       wake_busy          // Wake-up delay in progress
);

  // ----------------------------------------------------------------
  // Input synchronisers and peripheral classes
  // ----------------------------------------------------------------
  wire irq_s;
  wire rtc_s;
  wire io_s;

  lpmc_sync #(.W(3)) u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .d       ({irq_async, rtc_wake_async, io_wake_async}),
    .q       ({irq_s, rtc_s, io_s})
  );

  wire [2*`LPMC_NPER-1:0] cls;

  genvar gi;
  generate
    for (gi = 0; gi < `LPMC_NPER; gi = gi + 1) begin : g_cls
      lpmc_classify u_cls (
        .active    (per_active[gi]),
        .kind      (per_kind[3*gi +: 3]),
        .src       (per_src[2*gi +: 2]),
        .ext_fast  (per_ext_fast[gi]),
        .idle_wait (per_idle_wait[gi]),
        .cls       (cls[2*gi +: 2])
      );
    end
  endgenerate

  reg any_hf;
  reg any_lf;
  reg any_uc;
  integer k;

  always @* begin
    any_hf = 1'b0;
    any_lf = 1'b0;
    any_uc = 1'b0;
    for (k = 0; k < `LPMC_NPER; k = k + 1) begin
      any_hf = any_hf | (cls[2*k +: 2] == `LPMC_CLS_HF);
      any_lf = any_lf | (cls[2*k +: 2] == `LPMC_CLS_LF);
      any_uc = any_uc | (cls[2*k +: 2] == `LPMC_CLS_UNCLK);
    end
  end

  // ----------------------------------------------------------------
  // Mode grant: clamp request to deepest supported mode
  // ----------------------------------------------------------------
  reg [2:0] grant;

  always @* begin
    grant = lpm_req_mode;
    if (any_hf && lpm_req_mode > `LPMC_MODE_CPUOFF_B)
      grant = `LPMC_MODE_CPUOFF_B;
    else if (any_lf && lpm_req_mode > `LPMC_MODE_STANDBY_B)
      grant = `LPMC_MODE_STANDBY_B;
    else if (any_uc && lpm_req_mode > `LPMC_MODE_FULL_OFF)
      grant = `LPMC_MODE_FULL_OFF;
    // Requested zero means stay running; nothing to clamp
    if (lpm_req_mode == `LPMC_MODE_RUN)
      grant = `LPMC_MODE_RUN;
  end

  wire eng_busy = mpy_busy | crc_busy | aes_busy;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  localparam ST_RUN     = 3'h0;
  localparam ST_DEFER   = 3'h1;
  localparam ST_LOW     = 3'h2;
  localparam ST_WAKE    = 3'h3;
  localparam ST_ISR     = 3'h4;
  localparam ST_DMA     = 3'h5;
  localparam ST_SHUT    = 3'h6;
  localparam ST_BOOT    = 3'h7;

  localparam integer WAKE_FAST_N = `LPMC_WAKE_FAST_CYC;
  localparam integer WAKE_NVM_N  = `LPMC_WAKE_NVM_CYC;
  localparam [6:0]   WAKE_FAST   = WAKE_FAST_N[6:0];
  localparam [6:0]   WAKE_NVM    = WAKE_NVM_N[6:0];

  reg [2:0] st_q;
  reg [2:0] st_d;
  reg [2:0] mode_q;      // Mode held while low or visiting
  reg [2:0] mode_d;
  reg [6:0] wcnt_q;
  reg [6:0] wcnt_d;
  reg       wake_dma_q;  // Wake is for a DMA visit
  reg       wake_dma_d;
  reg       vec_q;       // Vector task started in run state
  reg       vec_d;

  wire shut_mode = (mode_q == `LPMC_MODE_RTC_SHUT) || (mode_q == `LPMC_MODE_DEEP_SHUT);
  wire shut_wake = rtc_s && (mode_q == `LPMC_MODE_RTC_SHUT) || io_s;
  // Memory-off wake costs extra only when the wake path reads it
  wire [6:0] wake_len = (nvm_disabled && wake_reads_nvm) ? WAKE_NVM : WAKE_FAST;

  always @* begin
    st_d       = st_q;
    mode_d     = mode_q;
    wcnt_d     = wcnt_q;
    wake_dma_d = wake_dma_q;
    vec_d      = vec_q;
    if (vec_done)
      vec_d = 1'b0;
    case (st_q)
      ST_RUN: begin
        if (vec_start)
          vec_d = 1'b1;
        if (lpm_req) begin
          mode_d = grant;
          if (grant != `LPMC_MODE_RUN)
            st_d = eng_busy ? ST_DEFER : ST_LOW;
        end
      end
      ST_DEFER: begin
        if (!eng_busy)
          st_d = ST_LOW;
      end
      ST_LOW: begin
        if (shut_mode)
          st_d = ST_SHUT;
        else if (irq_s) begin
          st_d       = ST_WAKE;
          wake_dma_d = 1'b0;
          wcnt_d     = wake_len;
        end else if (dma_trigger) begin
          st_d       = ST_WAKE;
          wake_dma_d = 1'b1;
          wcnt_d     = WAKE_FAST;
        end
      end
      ST_WAKE: begin
        if (wcnt_q > 7'h01)
          wcnt_d = wcnt_q - 7'h01;
        else
          st_d = wake_dma_q ? ST_DMA : ST_ISR;
      end
      ST_ISR: begin
        if (reti)
          st_d = ST_LOW;
      end
      ST_DMA: begin
        if (dma_done)
          st_d = ST_LOW;
      end
      ST_SHUT: begin
        if (shut_wake) begin
          st_d   = ST_BOOT;
          wcnt_d = WAKE_NVM;
          vec_d  = 1'b0;
        end
      end
      ST_BOOT: begin
        if (wcnt_q > 7'h01)
          wcnt_d = wcnt_q - 7'h01;
        else begin
          st_d   = ST_RUN;
          mode_d = `LPMC_MODE_RUN;
        end
      end
      default:
        st_d = ST_RUN;
    endcase
  end

  // ----------------------------------------------------------------
  // Output decode, registered
  // ----------------------------------------------------------------
  reg [2:0] eff_mode;
  reg       cpu_d;
  reg       mclk_d;
  reg       sub_system_clock_d;
  reg       aclk_d;
  reg       lf_d;
  reg       vrun_d;
  reg       core_d;
  reg       svs_d;
  reg       prst_d;

  always @* begin
    // Visits and deferral run in the run state's clocks
    case (st_d)
      ST_LOW, ST_SHUT: eff_mode = mode_d;
      default:         eff_mode = `LPMC_MODE_RUN;
    endcase
    cpu_d   = (eff_mode == `LPMC_MODE_RUN);
    mclk_d  = (eff_mode == `LPMC_MODE_RUN) ||
              (eff_mode == `LPMC_MODE_CPUOFF_A && vec_d);
    sub_system_clock_d = (eff_mode <= `LPMC_MODE_CPUOFF_B) && !sub_clock_disable;
    aclk_d  = (eff_mode <= `LPMC_MODE_STANDBY_B);
    lf_d    = (eff_mode <= `LPMC_MODE_STANDBY_B) ||
              (eff_mode == `LPMC_MODE_FULL_OFF && slow_clk_req) ||
              (eff_mode == `LPMC_MODE_RTC_SHUT);
    vrun_d  = vec_d && (eff_mode <= `LPMC_MODE_CPUOFF_A);
    core_d  = (eff_mode < `LPMC_MODE_RTC_SHUT);
    svs_d   = (eff_mode != `LPMC_MODE_DEEP_SHUT) || supply_supervisor_enable;
    prst_d  = !core_d || (st_d == ST_BOOT);
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q           <= ST_RUN;
      mode_q         <= `LPMC_MODE_RUN;
      wcnt_q         <= 7'h00;
      wake_dma_q     <= 1'b0;
      vec_q          <= 1'b0;
      cur_mode       <= `LPMC_MODE_RUN;
      cpu_clk_en     <= 1'b1;
      main_clk_en    <= 1'b1;
      sub_clk_en     <= 1'b1;
      aux_clk_en     <= 1'b1;
      lf_xtal_en     <= 1'b1;
      vlo_en         <= 1'b1;
      vec_run        <= 1'b0;
      core_supply_en <= 1'b1;
      supervisor_en  <= 1'b1;
      periph_rst     <= 1'b0;
      wake_busy      <= 1'b0;
    end else begin
      st_q           <= st_d;
      mode_q         <= mode_d;
      wcnt_q         <= wcnt_d;
      wake_dma_q     <= wake_dma_d;
      vec_q          <= vec_d;
      cur_mode       <= eff_mode;
      cpu_clk_en     <= cpu_d;
      main_clk_en    <= mclk_d;
      sub_clk_en     <= sub_system_clock_d;
      aux_clk_en     <= aclk_d;
      lf_xtal_en     <= lf_d;
      vlo_en         <= lf_d;
      vec_run        <= vrun_d;
      core_supply_en <= core_d;
      supervisor_en  <= svs_d;
      periph_rst     <= prst_d;
      wake_busy      <= (st_d == ST_WAKE) || (st_d == ST_BOOT);
    end
  end

endmodule
`default_nettype wire

// [verification/lpmc_ctrl_checker.sv]
// Assertion checker for the low-power mode controller
`timescale 1ns/100ps
`default_nettype none
`include "lpmc_map.vh"
module lpmc_ctrl_checker (
  input wire logic       ref_clk,        // System clock
  input wire logic       arst_n,         // Async reset, active low
  input wire logic       reti,           // ISR finished
  input wire logic       dma_done,       // DMA transfer finished
  input wire logic       vec_start,      // Vector task start
  input wire logic       mpy_busy,       // Multiplier busy
  input wire logic       crc_busy,       // CRC busy
  input wire logic       aes_busy,       // Cipher busy
  input wire logic       nvm_disabled,   // Memory off
  input wire logic       wake_reads_nvm, // Wake fetches from memory
  input wire logic       slow_clk_req,   // Slow-clock request
  input wire logic       irq_async,      // Interrupt pin
  input wire logic [2:0] cur_mode,       // Granted mode
  input wire logic       main_clk_en,    // Main clock on
  input wire logic       aux_clk_en,     // Auxiliary clock on
  input wire logic       lf_xtal_en,     // Crystal clock on
  input wire logic       vlo_en,         // Low-power oscillator on
  input wire logic       vec_run,        // Vector engine running
  input wire logic       core_supply_en, // Core supply on
  input wire logic       periph_rst,     // Peripheral reset
  input wire logic       wake_busy       // Wake delay running
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic [2:0] low_q;
  logic [7:0] wcnt_q;
  // Last low mode, needed to judge the return after a visit
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_q  <= 3'h0;
      wcnt_q <= 8'h00;
    end else begin
      if (cur_mode != 3'h0) low_q <= cur_mode;
      wcnt_q <= wake_busy ? wcnt_q + 8'h01 : 8'h00;
    end
  end
  sequence s_isr_end;
    cur_mode == 3'h0 && reti && !wake_busy && low_q inside {[3'h1:3'h5]};
  endsequence
  sequence s_dma_end;
    cur_mode == 3'h0 && dma_done && !wake_busy && low_q inside {[3'h1:3'h5]};
  endsequence
  a_isr_return: assert property (s_isr_end |=> cur_mode == low_q)
    else $error("mode not resumed after interrupt");
  a_dma_return: assert property (s_dma_end |=> cur_mode == low_q)
    else $error("mode not resumed after transfer");
  a_irq_wake_start: assert property ($rose(irq_async) && cur_mode inside {[3'h1:3'h5]} && !wake_busy
    |-> ##[1:4] wake_busy) else $error("interrupt did not wake");
  a_main_clk_modes: assert property (main_clk_en |-> cur_mode <= 3'h1)
    else $error("main clock on in deep mode");
  a_aux_deep_off: assert property (cur_mode >= 3'h5 |-> !aux_clk_en)
    else $error("aux clock on in off mode");
  a_vec_mode_stop: assert property (vec_run |-> cur_mode <= 3'h1)
    else $error("vector engine runs in deep mode");
  a_vec_no_start: assert property (cur_mode == 3'h1 && !vec_run && vec_start |=> !vec_run)
    else $error("vector engine started while cpu off");
  a_shut_supply_off: assert property (cur_mode >= 3'h6 |-> !core_supply_en && periph_rst)
    else $error("supply or reset wrong in shutdown");
  a_busy_defer: assert property (cur_mode == 3'h0 && !wake_busy && (mpy_busy || crc_busy || aes_busy)
    && !reti && !dma_done |=> cur_mode == 3'h0) else $error("entry while engine busy");
  a_slow_clk_keep: assert property (cur_mode == 3'h5 && slow_clk_req ##1 cur_mode == 3'h5
    |-> lf_xtal_en && vlo_en) else $error("slow clocks stopped on request");
  a_wake_len_ok: assert property ($fell(wake_busy) && !$past(periph_rst) |-> wcnt_q ==
    ((nvm_disabled && wake_reads_nvm) ? `LPMC_WAKE_NVM_CYC : `LPMC_WAKE_FAST_CYC))
    else $error("wake delay length wrong");
endmodule
bind lpmc_ctrl lpmc_ctrl_checker lpmc_ctrl_checker_i (.ref_clk, .arst_n, .reti, .dma_done, .vec_start,
  .mpy_busy, .crc_busy, .aes_busy, .nvm_disabled, .wake_reads_nvm, .slow_clk_req, .irq_async, .cur_mode,
  .main_clk_en, .aux_clk_en, .lf_xtal_en, .vlo_en, .vec_run, .core_supply_en, .periph_rst, .wake_busy);
`default_nettype wire

// [verification/lpmc_cpu_model.sv]
// CPU-side partner: ends interrupt service or DMA visit after a wake
`timescale 1ns/100ps
`default_nettype none
module lpmc_cpu_model (
  input  wire logic       ref_clk,   // System clock
  input  wire logic       arst_n,    // Async reset, active low
  input  wire logic       wake_busy, // Controller waking
  input  wire logic       svc_dma,   // Visit is a DMA transfer
  input  wire logic [1:0] svc_wait,  // Service cycles, 1 to 3
  output var  logic       reti,      // ISR finished
  output var  logic       dma_done   // DMA transfer finished
);
  logic       busy_q;
  logic [1:0] cnt_q;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q   <= 1'b0;
      cnt_q    <= 2'h0;
      reti     <= 1'b0;
      dma_done <= 1'b0;
    end else begin
      busy_q   <= wake_busy;
      reti     <= 1'b0;
      dma_done <= 1'b0;
      if (busy_q && !wake_busy) cnt_q <= svc_wait;
      else if (cnt_q != 2'h0) cnt_q <= cnt_q - 2'h1;
      if (cnt_q == 2'h1) begin
        reti     <= !svc_dma;
        dma_done <= svc_dma;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/tb_lpmc_ctrl.sv]
// Self-checking testbench for the low-power mode controller
`timescale 1ns/100ps
`default_nettype none
`include "lpmc_map.vh"
module tb_lpmc_ctrl;
  logic        ref_clk, arst_n, lpm_req, reti, vec_start, vec_done, mpy_busy, crc_busy, aes_busy;
  logic        dma_trigger, dma_done, nvm_disabled, wake_reads_nvm, sub_clock_disable, slow_clk_req;
  logic        supply_supervisor_enable, irq_async, rtc_wake_async, io_wake_async, svc_dma;
  logic        cpu_clk_en, main_clk_en, sub_clk_en, aux_clk_en, lf_xtal_en, vlo_en, vec_run;
  logic        core_supply_en, supervisor_en, periph_rst, wake_busy;
  logic [2:0]  lpm_req_mode, cur_mode;
  logic [7:0]  per_active, per_ext_fast, per_idle_wait;
  logic [23:0] per_kind;
  logic [15:0] per_src;
  logic [1:0]  svc_wait;
  int          bad_count, total_checks, cyc, n, wcnt;
  // Entries: kind, source, fast, idle, deepest grant
  logic [9:0]  per_tbl [14] = '{10'h002, 10'h024, 10'h00D, 10'h0F2, 10'h0E5, 10'h0FD, 10'h142,
                                10'h124, 10'h10D, 10'h182, 10'h1F2, 10'h1A4, 10'h1E5, 10'h205};
  lpmc_ctrl lpmc_ctrl_i (.ref_clk, .arst_n, .lpm_req, .lpm_req_mode, .reti, .vec_start, .vec_done,
    .mpy_busy, .crc_busy, .aes_busy, .dma_trigger, .dma_done, .nvm_disabled, .wake_reads_nvm,
    .sub_clock_disable, .supply_supervisor_enable, .slow_clk_req, .per_active, .per_kind, .per_src,
    .per_ext_fast, .per_idle_wait, .irq_async, .rtc_wake_async, .io_wake_async, .cur_mode, .cpu_clk_en,
    .main_clk_en, .sub_clk_en, .aux_clk_en, .lf_xtal_en, .vlo_en, .vec_run, .core_supply_en,
    .supervisor_en, .periph_rst, .wake_busy);
  lpmc_cpu_model lpmc_cpu_model_i (.ref_clk, .arst_n, .wake_busy, .svc_dma, .svc_wait, .reti, .dma_done);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = !ref_clk;
  end
  always @(negedge ref_clk) if (wake_busy === 1'b1) wcnt++;
  // Hang guard, far above the expected run length
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      complete_run();
    end
  end
  // ---------------------------------------
  // Tasks
  // ---------------------------------------
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic rst;
    @(posedge ref_clk);
    arst_n <= 1'b0;
    tick(2);
    arst_n <= 1'b1;
  endtask
  task automatic enter(logic [2:0] m);
    @(posedge ref_clk);
    lpm_req      <= 1'b1;
    lpm_req_mode <= m;
    @(posedge ref_clk);
    lpm_req <= 1'b0;
    tick(2);
    @(negedge ref_clk);
  endtask
  // Interrupt or DMA visit, then back to mode m
  task automatic wake(logic dma, logic [2:0] m, int len);
    @(posedge ref_clk);
    wcnt = 0;
    svc_dma     <= dma;
    dma_trigger <= dma;
    irq_async   <= !dma;
    @(posedge ref_clk);
    dma_trigger <= 1'b0;
    @(posedge ref_clk);
    irq_async <= 1'b0;
    n = 0;
    while ((wcnt == 0 || wake_busy !== 1'b0 || cur_mode === 3'h0) && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    check("wake in time", n < 200, 1'b1);
    check("wake length", wcnt[15:0], len[15:0]);
    check("resumed mode", cur_mode, m);
  endtask
  task automatic boot(logic rtc);
    @(posedge ref_clk);
    rtc_wake_async <= rtc;
    io_wake_async  <= !rtc;
    tick(3);
    rtc_wake_async <= 1'b0;
    io_wake_async  <= 1'b0;
    n = 0;
    while (periph_rst !== 1'b0 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    check("boot in time", n < 200, 1'b1);
    check("boot state", {cur_mode, core_supply_en}, 16'h0001);
  endtask
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ---------------------------------------
  // Sequence
  // ---------------------------------------
  initial begin
    {arst_n, lpm_req, vec_start, vec_done, mpy_busy, crc_busy, aes_busy, dma_trigger} = 8'h00;
    {nvm_disabled, wake_reads_nvm, sub_clock_disable, slow_clk_req, irq_async} = 5'h00;
    {rtc_wake_async, io_wake_async, svc_dma} = 3'h0;
    supply_supervisor_enable = 1'b1;
    {per_active, per_ext_fast, per_idle_wait, per_kind, per_src} = 64'h0;
    lpm_req_mode = 3'h0;
    svc_wait = 2'h1;
    tick(16);
    arst_n <= 1'b1;
    @(negedge ref_clk);
    check("reset outputs", {cur_mode, cpu_clk_en, main_clk_en, sub_clk_en, aux_clk_en, lf_xtal_en, vlo_en,
      vec_run, core_supply_en, supervisor_en, periph_rst, wake_busy}, 16'h07EC);
    for (int m = 1; m <= 5; m++) begin
      svc_wait <= (m % 2) ? 2'h1 : 2'h3;
      enter(m[2:0]);
      check("mode granted", cur_mode, m[2:0]);
      check("main, aux", {main_clk_en, aux_clk_en}, {1'b0, m <= 4});
      check("sub clock", {cpu_clk_en, sub_clk_en}, {1'b0, m <= 2});
      wake(1'b0, m[2:0], `LPMC_WAKE_FAST_CYC);
      rst();
    end
    $display("test modes done");
    for (int i = 0; i < 14; i++) begin
      @(posedge ref_clk);
      per_active    <= 8'h01;
      per_kind      <= {21'h000000, per_tbl[i][9:7]};
      per_src       <= {14'h0000, per_tbl[i][6:5]};
      per_ext_fast  <= {7'h00, per_tbl[i][4]};
      per_idle_wait <= {7'h00, per_tbl[i][3]};
      enter(3'h7);
      check("clamped grant", cur_mode, per_tbl[i][2:0]);
      wake(1'b0, per_tbl[i][2:0], `LPMC_WAKE_FAST_CYC);
      rst();
    end
    per_active <= 8'h00;
    $display("test clamp done");
    for (int b = 0; b < 3; b++) begin
      @(posedge ref_clk);
      {aes_busy, crc_busy, mpy_busy} <= 3'h1 << b;
      enter(3'h3);
      tick(4);
      check("deferred", cur_mode, 3'h0);
      {aes_busy, crc_busy, mpy_busy} <= 3'h0;
      tick(3);
      @(negedge ref_clk);
      check("entered after busy", cur_mode, 3'h3);
      wake(1'b0, 3'h3, `LPMC_WAKE_FAST_CYC);
      rst();
    end
    $display("test busy done");
    nvm_disabled <= 1'b1;
    enter(3'h4);
    wake(1'b1, 3'h4, `LPMC_WAKE_FAST_CYC);
    @(posedge ref_clk);
    wake_reads_nvm <= 1'b1;
    wake(1'b0, 3'h4, `LPMC_WAKE_NVM_CYC);
    rst();
    {nvm_disabled, wake_reads_nvm} <= 2'h0;
    $display("test dma done");
    @(posedge ref_clk);
    vec_start <= 1'b1;
    @(posedge ref_clk);
    vec_start <= 1'b0;
    enter(3'h1);
    check("vector task kept", {main_clk_en, vec_run}, 2'h3);
    @(posedge ref_clk);
    vec_done <= 1'b1;
    @(posedge ref_clk);
    vec_done  <= 1'b0;
    vec_start <= 1'b1;
    @(posedge ref_clk);
    vec_start <= 1'b0;
    tick(2);
    @(negedge ref_clk);
    check("no start in cpu off", {main_clk_en, vec_run}, 2'h0);
    rst();
    @(posedge ref_clk);
    vec_start <= 1'b1;
    @(posedge ref_clk);
    vec_start <= 1'b0;
    enter(3'h3);
    check("vector stopped", {main_clk_en, vec_run}, 2'h0);
    rst();
    $display("test vector done");
    slow_clk_req <= 1'b1;
    enter(3'h5);
    check("slow clocks", {lf_xtal_en, vlo_en, aux_clk_en}, 3'h6);
    rst();
    slow_clk_req      <= 1'b0;
    sub_clock_disable <= 1'b1;
    enter(3'h1);
    check("sub disabled", sub_clk_en, 1'b0);
    rst();
    sub_clock_disable        <= 1'b0;
    supply_supervisor_enable <= 1'b0;
    enter(3'h7);
    check("deep shutdown", {core_supply_en, periph_rst, supervisor_en}, 3'h2);
    boot(1'b0);
    @(posedge ref_clk);
    supply_supervisor_enable <= 1'b1;
    enter(3'h6);
    check("rtc shutdown", {core_supply_en, periph_rst, supervisor_en}, 3'h3);
    boot(1'b1);
    $display("test shutdown done");
    complete_run();
  end
endmodule
`default_nettype wire
